//--- pin_map_pkg.sv
// constants, types and reset values shared by the pin map protection block
package pin_map_pkg;

	// -----------------------------------------------------------------
	// register space
	// -----------------------------------------------------------------
	localparam int DATA_W = 16;
	localparam int ADDR_W = 6;
	localparam int IN_REGS = 19;
	localparam int OUT_REGS = 13;
	localparam int SEL_REGS = IN_REGS + OUT_REGS;
	localparam logic [ADDR_W-1:0] OSC_CTRL_IDX = 6'h20;
	localparam logic [ADDR_W-1:0] STATUS_IDX = 6'h21;
	localparam logic [ADDR_W-1:0] MASK_IDX = 6'h22;

	// -----------------------------------------------------------------
	// fields
	// -----------------------------------------------------------------
	localparam int FIELD_W = 6;
	localparam int FIELD_LO_LSB = 0;
	localparam int FIELD_HI_LSB = 8;
	localparam int LOCK_BIT = 6;
	localparam int ONE_WAY_BIT = 15;
	localparam logic [DATA_W-1:0] LOW_BYTE_MASK = 16'h00FF;
	localparam logic [DATA_W-1:0] FULL_WORD_MASK = 16'hFFFF;
	localparam logic [7:0] KEY_FIRST = 8'h46;
	localparam logic [7:0] KEY_SECOND = 8'h57;
	localparam logic [FIELD_W-1:0] IN_SEL_RESET = 6'h3F;
	localparam logic [FIELD_W-1:0] OUT_SEL_RESET = 6'h00;
	localparam logic [FIELD_W-1:0] NULL_OUTPUT = 6'h00;

	// -----------------------------------------------------------------
	// status bits (status and mask share this layout)
	// -----------------------------------------------------------------
	localparam int ST_W = 3;
	localparam int ST_MISMATCH = 0;
	localparam int ST_BLOCKED = 1;
	localparam int ST_ABANDON = 2;

	// -----------------------------------------------------------------
	// timing
	// -----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int KEY_WINDOW_NS = 40;
	localparam int KEY_WINDOW_CYC = (KEY_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 : KEY_WINDOW_NS / CLK_PERIOD_NS;
	localparam int TIMER_W = 4;

	typedef enum {KEY_IDLE, KEY_GOT_FIRST, KEY_GOT_SECOND} key_state_e;

	// reset image of one select register
	function automatic logic [DATA_W-1:0] sel_reset(input int idx);
		logic [FIELD_W-1:0] d;
		d = (idx < IN_REGS) ? IN_SEL_RESET : OUT_SEL_RESET;
		return {2'h0, d, 2'h0, d};
	endfunction : sel_reset

endpackage : pin_map_pkg

//--- pin_map_shadow.sv
// shadow copy of the select registers with a continuous compare
`timescale 1ns/100ps
`default_nettype none
module pin_map_shadow
	import pin_map_pkg::*;
(
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// permitted writes, mirrored from the live registers
	input wire logic i_wr_en,
	input wire logic [ADDR_W-1:0] i_wr_idx,
	input wire logic [DATA_W-1:0] i_wr_data,
	// live registers under watch
	input wire logic [SEL_REGS-1:0][DATA_W-1:0] i_live,
	// compare result
	output logic o_mismatch
);

	typedef struct packed {
		logic [SEL_REGS-1:0][DATA_W-1:0] sh;
		logic mismatch;
	} shadow_s;

	shadow_s st_r;
	shadow_s st_nxt;

	assign o_mismatch = st_r.mismatch;

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (i_wr_en) begin
			st_nxt.sh[i_wr_idx[4:0]] = i_wr_data;
		end
		// any live bit that drifts from its shadow flags a mismatch
		st_nxt.mismatch = (i_live != st_r.sh);
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			for (int i = 0; i < SEL_REGS; i++) begin
				st_r.sh[i] <= sel_reset(i);
			end
			st_r.mismatch <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

endmodule : pin_map_shadow
`default_nettype wire

//--- pin_map_write_protection.sv
// remappable pin map with write lock, key sequence, one-way lock and shadow check
// What this block does
// - locked writes to select registers change nothing but raise the blocked-write status event
// - lock is bit 6 of oscillator control; one blocks, zero permits
// - lock changes only after byte writes 46h then 57h, then one write
// - lock holds its value until software changes it; never relocks itself
// - shadow copies compared continuously; drift raises configuration-mismatch reset
// - with one-way lock config set, a set lock cannot be cleared
// - in that case only device reset clears the lock
// - one-way config bit set allows one session; cleared allows unlimited sessions
// - reset loads input fields 111111 and output fields 000000
// - lock resets unlocked so select registers are writable at once
// - routing never touches pin direction or enables a peripheral
// - a pin set analog stays analog; its digital input reads zero
// - thirty-two protected registers: nineteen input, thirteen output select
// - each output select register holds two six-bit pin fields
// - unimplemented pin codes leave inputs unconnected; their output fields ignore writes
`timescale 1ns/100ps
`default_nettype none
module pin_map_write_protection
	import pin_map_pkg::*;
#(
	parameter logic [63:0] PIN_IMPL = 64'h0000_0000_00FF_EFEF,
	parameter int N_OUT_FUNCS = 28
) (
	// clock and reset
	input wire logic i_core_clk,
	input wire logic i_sys_rst,
	// register port
	input wire logic [ADDR_W-1:0] i_addr,
	input wire logic [DATA_W-1:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_wr_byte,
	input wire logic i_rd,
	output logic [DATA_W-1:0] o_rdata,
	// configuration fuses
	input wire logic [DATA_W-1:0] i_config_word_four,
	// cell disturbance on the live select registers
	input wire logic i_disturb,
	input wire logic [4:0] i_disturb_idx,
	input wire logic [DATA_W-1:0] i_disturb_bits,
	// pins and peripherals
	input wire logic [63:0] i_pin_in,
	input wire logic [63:0] i_pin_analog,
	input wire logic [63:0] i_periph_out,
	output logic [2*IN_REGS-1:0] o_periph_in,
	output logic [2*OUT_REGS-1:0] o_pin_out,
	// events
	output logic o_cfg_mismatch_rst,
	output logic o_irq
);

	localparam int IN_FIELDS = 2 * IN_REGS;
	localparam int OUT_PINS = 2 * OUT_REGS;
	localparam logic [TIMER_W-1:0] KEY_WINDOW = TIMER_W'(KEY_WINDOW_CYC);

	typedef struct packed {
		logic [SEL_REGS-1:0][DATA_W-1:0] sel;
		logic map_write_lock;
		key_state_e key;
		logic [TIMER_W-1:0] timer;
		logic [ST_W-1:0] status;
		logic [ST_W-1:0] mask;
		logic [DATA_W-1:0] rdata;
		logic irq;
		logic mismatch_rst;
		logic [IN_FIELDS-1:0] periph_in;
		logic [OUT_PINS-1:0] pin_out;
	} state_s;

	state_s st_r;
	state_s st_nxt;
	logic shadow_mismatch;
	logic sel_hit;
	logic osc_wr;
	logic one_way;
	logic perm_wr;
	logic [DATA_W-1:0] perm_data;
	logic [DATA_W-1:0] wmask;

	// writable bits of a select register; output fields of absent pins stay zero
	function automatic logic [DATA_W-1:0] field_mask(input logic [ADDR_W-1:0] idx);
		logic [DATA_W-1:0] m;
		int pin;
		m = {2'h0, {FIELD_W{1'b1}}, 2'h0, {FIELD_W{1'b1}}};
		pin = 2 * (int'(idx) - IN_REGS);
		if (int'(idx) >= IN_REGS) begin
			if (!PIN_IMPL[pin]) begin
				m[FIELD_LO_LSB +: FIELD_W] = '0;
			end
			if (!PIN_IMPL[pin+1]) begin
				m[FIELD_HI_LSB +: FIELD_W] = '0;
			end
		end
		return m;
	endfunction : field_mask

	// one six-bit field of a select register
	function automatic logic [FIELD_W-1:0] get_field(input logic [DATA_W-1:0] r, input logic hi);
		return hi ? r[FIELD_HI_LSB +: FIELD_W] : r[FIELD_LO_LSB +: FIELD_W];
	endfunction : get_field

	assign o_rdata = st_r.rdata;
	assign o_irq = st_r.irq;
	assign o_cfg_mismatch_rst = st_r.mismatch_rst;
	assign o_periph_in = st_r.periph_in;
	assign o_pin_out = st_r.pin_out;

	// unprogrammed fuse reads one, meaning one write session only
	assign one_way = i_config_word_four[ONE_WAY_BIT];
	assign wmask = i_wr_byte ? LOW_BYTE_MASK : FULL_WORD_MASK;
	// thirty-two protected select registers from index zero
	assign sel_hit = (int'(i_addr) < SEL_REGS);
	assign osc_wr = i_wr && (i_addr == OSC_CTRL_IDX);
	// select writes land only while unlocked
	assign perm_wr = i_wr && sel_hit && !st_r.map_write_lock;
	assign perm_data = (st_r.sel[i_addr[4:0]] & ~(wmask & field_mask(i_addr)))
		| (i_wdata & wmask & field_mask(i_addr));

	// -----------------------------------------------------------------
	// shadow compare
	// -----------------------------------------------------------------
	pin_map_shadow u_shadow (
		.i_core_clk(i_core_clk),
		.i_sys_rst(i_sys_rst),
		.i_wr_en(perm_wr),
		.i_wr_idx(i_addr),
		.i_wr_data(perm_data),
		.i_live(st_r.sel),
		.o_mismatch(shadow_mismatch)
	);

	// -----------------------------------------------------------------
	// next state
	// -----------------------------------------------------------------
	always_comb begin
		logic [ST_W-1:0] ev;
		logic [FIELD_W-1:0] code;
		ev = '0;
		code = '0;
		st_nxt = st_r;

		if (perm_wr) begin
			st_nxt.sel[i_addr[4:0]] = perm_data;
		end else if (i_wr && sel_hit) begin
			ev[ST_BLOCKED] = 1'b1;
		end
		if (i_disturb) begin
			st_nxt.sel[i_disturb_idx] = st_nxt.sel[i_disturb_idx] ^ i_disturb_bits;
		end

		// key sequence on the oscillator control register
		case (st_r.key)
			KEY_IDLE: begin
				// first key byte opens the sequence
				if (osc_wr && i_wr_byte && i_wdata[7:0] == KEY_FIRST) begin
					st_nxt.key = KEY_GOT_FIRST;
					st_nxt.timer = KEY_WINDOW;
				end
			end
			KEY_GOT_FIRST: begin
				if (osc_wr && i_wr_byte && i_wdata[7:0] == KEY_SECOND) begin
					st_nxt.key = KEY_GOT_SECOND;
					st_nxt.timer = KEY_WINDOW;
				end else if (osc_wr || st_r.timer == '0) begin
					// stray write or late step abandons
					st_nxt.key = KEY_IDLE;
					ev[ST_ABANDON] = 1'b1;
				end else begin
					st_nxt.timer = st_r.timer - 1'b1;
				end
			end
			KEY_GOT_SECOND: begin
				if (osc_wr) begin
					st_nxt.key = KEY_IDLE;
					// one-way fuse refuses clearing a set lock
					if (!(one_way && st_r.map_write_lock)) begin
						st_nxt.map_write_lock = i_wdata[LOCK_BIT];
					end
				end else if (st_r.timer == '0) begin
					st_nxt.key = KEY_IDLE;
					ev[ST_ABANDON] = 1'b1;
				end else begin
					st_nxt.timer = st_r.timer - 1'b1;
				end
			end
			default: begin
				st_nxt.key = KEY_IDLE;
			end
		endcase

		// mismatch raises the reset request and a status event
		ev[ST_MISMATCH] = shadow_mismatch;
		st_nxt.mismatch_rst = shadow_mismatch;

		if (i_wr && i_addr == MASK_IDX) begin
			st_nxt.mask = i_wdata[ST_W-1:0];
		end

		// read data for the next cycle; reading status clears it, a new event wins
		st_nxt.rdata = '0;
		if (i_rd) begin
			if (sel_hit) begin
				st_nxt.rdata = st_r.sel[i_addr[4:0]];
			end else if (i_addr == OSC_CTRL_IDX) begin
				st_nxt.rdata[LOCK_BIT] = st_r.map_write_lock;
			end else if (i_addr == STATUS_IDX) begin
				st_nxt.rdata[ST_W-1:0] = st_r.status;
			end else if (i_addr == MASK_IDX) begin
				st_nxt.rdata[ST_W-1:0] = st_r.mask;
			end
		end
		st_nxt.status = ((i_rd && i_addr == STATUS_IDX) ? '0 : st_r.status) | ev;
		st_nxt.irq = |(st_nxt.status & st_nxt.mask);

		// absent pin code leaves the input low
		// analog pins feed no digital input
		for (int f = 0; f < IN_FIELDS; f++) begin
			code = get_field(st_r.sel[f/2], f[0]);
			st_nxt.periph_in[f] = PIN_IMPL[code] && !i_pin_analog[code] && i_pin_in[code];
		end
		// two six-bit fields per output register choose each pin's source
		// only data is routed; direction and enables stay elsewhere
		for (int p = 0; p < OUT_PINS; p++) begin
			code = get_field(st_r.sel[IN_REGS + p/2], p[0]);
			st_nxt.pin_out[p] = PIN_IMPL[p] && code != NULL_OUTPUT
				&& int'(code) < N_OUT_FUNCS && i_periph_out[code];
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_sys_rst) begin
			// inputs tied low, outputs null after reset
			for (int i = 0; i < SEL_REGS; i++) begin
				st_r.sel[i] <= sel_reset(i);
			end
			st_r.map_write_lock <= 1'b0;
			st_r.key <= KEY_IDLE;
			st_r.timer <= '0;
			st_r.status <= '0;
			st_r.mask <= '0;
			st_r.rdata <= '0;
			st_r.irq <= 1'b0;
			st_r.mismatch_rst <= 1'b0;
			st_r.periph_in <= '0;
			st_r.pin_out <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_sys_rst);

	locked_write_a: assert property (i_wr && sel_hit && st_r.map_write_lock && !i_disturb
		|=> st_r.sel == $past(st_r.sel))
		else $error("locked select write changed the map");

	reset_image_a: assert property (disable iff (1'b0) $past(i_sys_rst) && !i_sys_rst
		|-> !st_r.map_write_lock && st_r.sel[0] == sel_reset(0) && st_r.sel[SEL_REGS-1] == sel_reset(SEL_REGS-1))
		else $error("reset image of map or lock wrong");

	key_apply_a: assert property (st_r.key == KEY_GOT_SECOND && osc_wr && !(one_way && st_r.map_write_lock)
		|=> st_r.map_write_lock == $past(i_wdata[LOCK_BIT]) && st_r.key == KEY_IDLE)
		else $error("lock not taken after key sequence");

	lock_hold_a: assert property (!(st_r.key == KEY_GOT_SECOND && osc_wr)
		|=> $stable(st_r.map_write_lock))
		else $error("lock moved without key sequence");

	one_way_a: assert property (one_way && st_r.map_write_lock
		|=> st_r.map_write_lock)
		else $error("one-way lock cleared");

	abandon_seq_a: assert property (st_r.key == KEY_GOT_FIRST && osc_wr && !(i_wr_byte && i_wdata[7:0] == KEY_SECOND)
		|=> st_r.key == KEY_IDLE && st_r.status[ST_ABANDON] ##1 $stable(st_r.map_write_lock))
		else $error("stray write did not abandon key sequence");

	mismatch_rst_a: assert property (i_disturb && i_disturb_bits != '0 ##1 !perm_wr
		|-> ##2 o_cfg_mismatch_rst)
		else $error("disturbed map raised no mismatch reset");

	blocked_irq_a: assert property (i_wr && sel_hit && st_r.map_write_lock && st_r.mask[ST_BLOCKED]
		|=> st_r.status[ST_BLOCKED] && o_irq)
		else $error("blocked select write raised no interrupt");

	absent_input_a: assert property (!PIN_IMPL[get_field(st_r.sel[0], 1'b0)]
		|=> !o_periph_in[0])
		else $error("absent pin code fed a peripheral input");

endmodule : pin_map_write_protection
`default_nettype wire

//--- pin_map_write_protection_bench.sv
// self-checking bench for the pin map protection block
`timescale 1ns/100ps
`default_nettype none
module pin_map_write_protection_bench import pin_map_pkg::*;;
	// -----------------------------------------------------------------
	// stimulus and observation
	// -----------------------------------------------------------------
	logic i_core_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic [ADDR_W-1:0] i_addr = '0;
	logic [DATA_W-1:0] i_wdata = '0;
	logic i_wr = 1'b0;
	logic i_wr_byte = 1'b0;
	logic i_rd = 1'b0;
	logic [DATA_W-1:0] i_config_word_four = '0;
	logic i_disturb = 1'b0;
	logic [4:0] i_disturb_idx = '0;
	logic [DATA_W-1:0] i_disturb_bits = '0;
	logic [63:0] i_pin_in = '0;
	logic [63:0] i_pin_analog = '0;
	logic [63:0] i_periph_out = '0;
	logic [DATA_W-1:0] o_rdata;
	logic [2*IN_REGS-1:0] o_periph_in;
	logic [2*OUT_REGS-1:0] o_pin_out;
	logic o_cfg_mismatch_rst;
	logic o_irq;
	logic rd_q = 1'b0;
	logic [DATA_W-1:0] exp_q[$];
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	int seed;

	always #5 i_core_clk = ~i_core_clk;

	pin_map_write_protection dut (.i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_wr_byte(i_wr_byte), .i_rd(i_rd), .o_rdata(o_rdata),
		.i_config_word_four(i_config_word_four), .i_disturb(i_disturb), .i_disturb_idx(i_disturb_idx),
		.i_disturb_bits(i_disturb_bits), .i_pin_in(i_pin_in), .i_pin_analog(i_pin_analog),
		.i_periph_out(i_periph_out), .o_periph_in(o_periph_in), .o_pin_out(o_pin_out),
		.o_cfg_mismatch_rst(o_cfg_mismatch_rst), .o_irq(o_irq));

	// -----------------------------------------------------------------
	// tasks
	// -----------------------------------------------------------------
	task automatic end_of_test();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d, input logic b);
		@(posedge i_core_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr_byte <= b;
		i_wr <= 1'b1;
		@(posedge i_core_clk);
		i_wr <= 1'b0;
		i_wr_byte <= 1'b0;
	endtask : wr

	// the expected read value is noted here and compared by the monitor
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
		exp_q.push_back(e);
		@(posedge i_core_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_core_clk);
		i_rd <= 1'b0;
	endtask : rd

	task automatic key(input logic [DATA_W-1:0] d);
		wr(OSC_CTRL_IDX, {8'h00, KEY_FIRST}, 1'b1);
		wr(OSC_CTRL_IDX, {8'h00, KEY_SECOND}, 1'b1);
		wr(OSC_CTRL_IDX, d, 1'b0);
	endtask : key

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge i_core_clk);
		@(negedge i_core_clk);
	endtask : wait_cyc

	task automatic do_reset();
		@(posedge i_core_clk);
		i_sys_rst <= 1'b1;
		repeat (10) @(posedge i_core_clk);
		i_sys_rst <= 1'b0;
	endtask : do_reset

	// -----------------------------------------------------------------
	// monitor and timeout
	// -----------------------------------------------------------------
	always @(posedge i_core_clk) begin
		rd_q <= i_rd;
		cycles++;
		if (cycles == 5000) begin
			num_errors++;
			end_of_test();
		end
	end

	always @(negedge i_core_clk) begin
		if (rd_q) begin
			check(o_rdata, exp_q.pop_front());
		end
	end

	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	initial begin
		logic [DATA_W-1:0] d;
		logic [DATA_W-1:0] wd[6];
		logic [ADDR_W-1:0] ra[6];
		logic [DATA_W-1:0] rm[6];
		int n;
		seed = 32'h87D92DCF;
		ra = '{6'h01, 6'h12, 6'h14, 6'h15, 6'h19, 6'h1F};
		rm = '{16'h3F3F, 16'h3F3F, 16'h3F3F, 16'h3F00, 16'h3F00, 16'h0000};
		do_reset();
		rd(6'h00, 16'h3F3F);
		rd(6'h12, 16'h3F3F);
		rd(6'h13, 16'h0000);
		rd(6'h1F, 16'h0000);
		rd(OSC_CTRL_IDX, 16'h0000);
		rd(6'h3F, 16'h0000);
		wr(MASK_IDX, 16'h0007, 1'b0);
		rd(MASK_IDX, 16'h0007);
		d = 16'($random(seed));
		wr(6'h00, d, 1'b0);
		rd(6'h00, d & 16'h3F3F);
		key(16'h0040);
		rd(OSC_CTRL_IDX, 16'h0040);
		wr(6'h00, ~d, 1'b0);
		rd(6'h00, d & 16'h3F3F);
		wait_cyc(2);
		check({15'h0, o_irq}, 16'h0001);
		rd(STATUS_IDX, 16'h0002);
		wait_cyc(2);
		check({15'h0, o_irq}, 16'h0000);
		// key sequence broken by a foreign write
		wr(OSC_CTRL_IDX, 16'h0046, 1'b1);
		wr(OSC_CTRL_IDX, 16'h0000, 1'b0);
		wr(OSC_CTRL_IDX, 16'h0057, 1'b1);
		wr(OSC_CTRL_IDX, 16'h0000, 1'b0);
		rd(OSC_CTRL_IDX, 16'h0040);
		rd(STATUS_IDX, 16'h0004);
		// key step arriving after the window is dropped
		wr(OSC_CTRL_IDX, 16'h0046, 1'b1);
		wait_cyc(8);
		wr(OSC_CTRL_IDX, 16'h0057, 1'b1);
		wr(OSC_CTRL_IDX, 16'h0000, 1'b0);
		rd(OSC_CTRL_IDX, 16'h0040);
		rd(STATUS_IDX, 16'h0004);
		key(16'h0000);
		rd(OSC_CTRL_IDX, 16'h0000);
		// one unlock serves many writes
		for (int k = 0; k < 6; k++) begin
			wd[k] = 16'($random(seed));
			wr(ra[k], wd[k], 1'b0);
		end
		for (int k = 0; k < 6; k++) begin
			rd(ra[k], wd[k] & rm[k]);
		end
		// routing follows the select fields only
		wr(6'h00, 16'h0002, 1'b0);
		wr(6'h13, 16'h0005, 1'b0);
		for (int k = 0; k < 4; k++) begin
			@(posedge i_core_clk);
			i_pin_in <= {$random(seed), $random(seed)};
			i_periph_out <= {$random(seed), $random(seed)};
			wait_cyc(3);
			check({15'h0, o_periph_in[0]}, {15'h0, i_pin_in[2]});
			check({15'h0, o_pin_out[0]}, {15'h0, i_periph_out[5]});
		end
		@(posedge i_core_clk);
		i_pin_in <= '1;
		i_pin_analog <= 64'h4;
		wait_cyc(3);
		check({15'h0, o_periph_in[0]}, 16'h0000);
		check({15'h0, o_cfg_mismatch_rst}, 16'h0000);
		// park the input on an absent pin code
		wr(6'h00, 16'h0004, 1'b0);
		wait_cyc(3);
		check({15'h0, o_periph_in[0]}, 16'h0000);
		// one-way configuration
		wr(MASK_IDX, 16'h0000, 1'b0);
		i_config_word_four <= 16'h8000;
		key(16'h0040);
		key(16'h0000);
		rd(OSC_CTRL_IDX, 16'h0040);
		wr(6'h00, 16'h0101, 1'b0);
		rd(6'h00, 16'h0004);
		wait_cyc(2);
		check({15'h0, o_irq}, 16'h0000);
		do_reset();
		rd(OSC_CTRL_IDX, 16'h0000);
		rd(6'h00, 16'h3F3F);
		wait_cyc(1);
		check({15'h0, |o_periph_in}, 16'h0000);
		check({15'h0, |o_pin_out}, 16'h0000);
		wr(6'h00, 16'h0707, 1'b0);
		rd(6'h00, 16'h0707);
		// upset of a live select register
		wr(MASK_IDX, 16'h0001, 1'b0);
		@(posedge i_core_clk);
		i_disturb_idx <= 5'd3;
		i_disturb_bits <= 16'h0001;
		i_disturb <= 1'b1;
		@(posedge i_core_clk);
		i_disturb <= 1'b0;
		n = 0;
		while (o_cfg_mismatch_rst !== 1'b1 && n < 8) begin
			@(negedge i_core_clk);
			n++;
		end
		check({15'h0, o_cfg_mismatch_rst}, 16'h0001);
		wait_cyc(2);
		check({15'h0, o_irq}, 16'h0001);
		rd(STATUS_IDX, 16'h0001);
		do_reset();
		wait_cyc(1);
		check({15'h0, o_cfg_mismatch_rst}, 16'h0000);
		wait_cyc(3);
		end_of_test();
	end
endmodule : pin_map_write_protection_bench
`default_nettype wire
